// >>> include/ptc_consts.svh
`ifndef PTC_CONSTS_SVH
`define PTC_CONSTS_SVH

// Serial bus slave address
`define PTC_DEV_ADDR 7'h23

// Register offsets
`define PTC_OFS_CTRL 8'h81
`define PTC_OFS_EMIT 8'h82
`define PTC_OFS_RATE 8'h84
`define PTC_OFS_FLAGS 8'h8C
`define PTC_OFS_RES_LO 8'h8D
`define PTC_OFS_RES_HI 8'h8E
`define PTC_OFS_IRQ 8'h8F
`define PTC_OFS_UP_LO 8'h90
`define PTC_OFS_UP_HI 8'h91
`define PTC_OFS_LO_LO 8'h92
`define PTC_OFS_LO_HI 8'h93
`define PTC_OFS_COMP_HI 8'h94
`define PTC_OFS_COMP_LO 8'h95
`define PTC_OFS_FILT 8'h9E

// Reset values
`define PTC_RST_CTRL 8'h00
`define PTC_RST_EMIT 8'h7F
`define PTC_RST_RATE 8'h02
`define PTC_RST_IRQ 8'h00
`define PTC_RST_UP 11'h7FF
`define PTC_RST_LO 11'h000
`define PTC_RST_COMP 11'h000
`define PTC_RST_FILT 4'h0

// Field positions
`define PTC_CTRL_ACTIVE 1:0
`define PTC_CTRL_GAIN 3:2
`define PTC_CTRL_SAT_EN 5
`define PTC_EMIT_FREQ 7:5
`define PTC_EMIT_DUTY 4:3
`define PTC_EMIT_CURR 2:0
`define PTC_IRQ_MODE 1:0
`define PTC_IRQ_POL 2
`define PTC_FILT_CNT 7:4
`define PTC_FLAG_IRQ 1
`define PTC_FLAG_NEW 0
`define PTC_HI_BITS 2:0
`define PTC_SAT_BIT 7

`endif

// >>> include/ptc_pkg.sv
package ptc_pkg;

    // Serial slave states, Gray along the usual path
    typedef enum logic [3:0] {
        PTC_S_IDLE = 4'h0,
        PTC_S_ADDR = 4'h1,
        PTC_S_AACK = 4'h3,
        PTC_S_REG = 4'h2,
        PTC_S_RACK = 4'h6,
        PTC_S_WR = 4'h7,
        PTC_S_WACK = 4'h5,
        PTC_S_RD = 4'h4,
        PTC_S_MACK = 4'hC
    } ptc_state_t;

    // Emitter drive settings toward the LED driver
    typedef struct packed {
        logic [2:0] freq;
        logic [1:0] duty;
        logic [2:0] current;
    } ptc_emitter_t;

    // Measurement settings toward the front end
    typedef struct packed {
        logic enable;
        logic [1:0] gain;
        logic [3:0] rate;
    } ptc_meas_cfg_t;

endpackage : ptc_pkg

// >>> rtl/ptc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.svh"

module ptc_regs
    import ptc_pkg::*;
#(
    parameter int RES_W = 11 // Result and limit width
) (
    input wire logic clock, // 25 MHz system clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic scl_i, // Serial clock level
    input wire logic sda_i, // Serial data level
    output logic sda_o, // Serial data drive level
    output logic sda_oe, // Serial data drive enable
    output logic int_o, // Interrupt pin drive level
    output logic int_oe, // Interrupt pin drive enable
    input wire logic raw_valid, // Raw result strobe
    input wire logic [RES_W-1:0] raw_data, // Raw proximity result
    input wire logic raw_sat, // Front end saturated
    output ptc_meas_cfg_t meas_cfg, // Enable, gain, interval
    output ptc_emitter_t emitter, // LED drive settings
    output logic [RES_W-1:0] result // Compensated result
);

    // Width check
    initial begin
        if (RES_W != 11) begin
            $error("ptc_regs: RES_W must be 11");
        end
    end

    // Reset synchroniser
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Register storage
    logic [7:0] ctrl_q; // Sensing control
    logic [7:0] emit_q; // Emitter drive
    logic [7:0] rate_q; // Repeat interval
    logic [7:0] irq_q; // Interrupt pin setup
    logic [RES_W-1:0] up_q; // Upper limit
    logic [RES_W-1:0] lo_q; // Lower limit
    logic [RES_W-1:0] comp_q; // Compensation value
    logic [3:0] filt_q; // Out-of-range count setting
    logic [RES_W-1:0] res_q; // Readable result
    logic res_sat_q; // Readable saturation flag
    logic [RES_W-1:0] pend_q; // Result held aside
    logic pend_sat_q; // Saturation held aside
    logic pend_vld_q; // Held result waiting
    logic new_q; // New data flag
    logic irq_flag_q; // Interrupt status flag
    logic [3:0] run_q; // Consecutive outliers seen

    // Serial slave state
    ptc_state_t state_q;
    logic scl_q; // Previous clock level
    logic sda_q; // Previous data level
    logic [3:0] bit_q; // Bit counter
    logic [7:0] shift_q; // Receive shifter
    logic [7:0] tx_q; // Transmit shifter
    logic [7:0] ptr_q; // Register pointer
    logic rw_q; // Read transfer
    logic mack_q; // Master acknowledged
    logic wr_q; // Write pulse
    logic [7:0] wdata_q; // Write data
    logic rd_q; // Read pulse
    logic [7:0] rptr_q; // Address of read
    logic oe_q; // Data drive enable

    // Bus condition detection
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic lock;
    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_c = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_c = scl_i & scl_q & ~sda_q & sda_i;
    assign lock = (state_q != PTC_S_IDLE);

    // Read multiplexer
    logic [7:0] rdata;
    always_comb begin
        rdata = 8'h00;
        case (ptr_q)
            `PTC_OFS_CTRL: rdata = ctrl_q;
            `PTC_OFS_EMIT: rdata = emit_q;
            `PTC_OFS_RATE: rdata = rate_q;
            `PTC_OFS_FLAGS: rdata = {6'h00, irq_flag_q, new_q};
            `PTC_OFS_RES_LO: rdata = res_q[7:0];
            `PTC_OFS_RES_HI: rdata = {res_sat_q, 4'h0, res_q[10:8]};
            `PTC_OFS_IRQ: rdata = irq_q;
            `PTC_OFS_UP_LO: rdata = up_q[7:0];
            `PTC_OFS_UP_HI: rdata = {5'h00, up_q[10:8]};
            `PTC_OFS_LO_LO: rdata = lo_q[7:0];
            `PTC_OFS_LO_HI: rdata = {5'h00, lo_q[10:8]};
            `PTC_OFS_COMP_HI: rdata = {5'h00, comp_q[10:8]};
            `PTC_OFS_COMP_LO: rdata = comp_q[7:0];
            `PTC_OFS_FILT: rdata = {filt_q, 4'h0};
            default: rdata = 8'h00; // Unmapped reads zero
        endcase
    end

    // Line history for edge detection
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // Serial slave sequencer
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= PTC_S_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            wr_q <= 1'b0;
            wdata_q <= 8'h00;
            rd_q <= 1'b0;
            rptr_q <= 8'h00;
            oe_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (start_c) begin
                // Start or repeated start
                state_q <= PTC_S_ADDR;
                bit_q <= 4'h0;
                oe_q <= 1'b0;
            end else if (stop_c) begin
                // Stop ends every transfer
                state_q <= PTC_S_IDLE;
                oe_q <= 1'b0;
            end else begin
                case (state_q)
                    PTC_S_IDLE: begin
                        oe_q <= 1'b0;
                    end
                    PTC_S_ADDR, PTC_S_REG, PTC_S_WR: begin
                        // Shift in eight bits, act on the eighth fall
                        if (scl_rise && bit_q < 4'h8) begin
                            shift_q <= {shift_q[6:0], sda_i};
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (state_q == PTC_S_ADDR) begin
                                if (shift_q[7:1] == `PTC_DEV_ADDR) begin
                                    rw_q <= shift_q[0];
                                    oe_q <= 1'b1;
                                    state_q <= PTC_S_AACK;
                                end else begin
                                    state_q <= PTC_S_IDLE; // Not ours
                                end
                            end else if (state_q == PTC_S_REG) begin
                                ptr_q <= shift_q;
                                oe_q <= 1'b1;
                                state_q <= PTC_S_RACK;
                            end else begin
                                wr_q <= 1'b1;
                                wdata_q <= shift_q;
                                oe_q <= 1'b1;
                                state_q <= PTC_S_WACK;
                            end
                        end
                    end
                    PTC_S_AACK: begin
                        // End of address acknowledge
                        if (scl_fall) begin
                            if (rw_q) begin
                                tx_q <= rdata;
                                rd_q <= 1'b1;
                                rptr_q <= ptr_q;
                                oe_q <= ~rdata[7];
                                state_q <= PTC_S_RD;
                            end else begin
                                oe_q <= 1'b0;
                                state_q <= PTC_S_REG;
                            end
                        end
                    end
                    PTC_S_RACK: begin
                        if (scl_fall) begin
                            oe_q <= 1'b0;
                            state_q <= PTC_S_WR;
                        end
                    end
                    PTC_S_WACK: begin
                        // Pointer advances after each written byte
                        if (scl_fall) begin
                            oe_q <= 1'b0;
                            ptr_q <= ptr_q + 8'h01;
                            state_q <= PTC_S_WR;
                        end
                    end
                    PTC_S_RD: begin
                        // Drive bits out on each falling edge
                        if (scl_rise) begin
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_q == 4'h8) begin
                                bit_q <= 4'h0;
                                oe_q <= 1'b0;
                                ptr_q <= ptr_q + 8'h01;
                                state_q <= PTC_S_MACK;
                            end else begin
                                tx_q <= {tx_q[6:0], 1'b0};
                                oe_q <= ~tx_q[6];
                            end
                        end
                    end
                    PTC_S_MACK: begin
                        // Master ack continues, nack ends
                        if (scl_rise) begin
                            mack_q <= ~sda_i;
                        end else if (scl_fall) begin
                            if (mack_q) begin
                                tx_q <= rdata;
                                rd_q <= 1'b1;
                                rptr_q <= ptr_q;
                                oe_q <= ~rdata[7];
                                state_q <= PTC_S_RD;
                            end else begin
                                state_q <= PTC_S_MACK; // Hold read lock until stop
                            end
                        end
                    end
                    default: begin
                        state_q <= PTC_S_IDLE;
                        oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Register writes
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            ctrl_q <= `PTC_RST_CTRL;
            emit_q <= `PTC_RST_EMIT;
            rate_q <= `PTC_RST_RATE;
            irq_q <= `PTC_RST_IRQ;
            up_q <= `PTC_RST_UP;
            lo_q <= `PTC_RST_LO;
            comp_q <= `PTC_RST_COMP;
            filt_q <= `PTC_RST_FILT;
        end else if (wr_q) begin
            case (ptr_q)
                `PTC_OFS_CTRL: ctrl_q <= wdata_q;
                `PTC_OFS_EMIT: emit_q <= wdata_q;
                `PTC_OFS_RATE: rate_q <= wdata_q;
                `PTC_OFS_IRQ: irq_q <= {5'h00, wdata_q[2:0]};
                `PTC_OFS_UP_LO: up_q[7:0] <= wdata_q;
                `PTC_OFS_UP_HI: up_q[10:8] <= wdata_q[`PTC_HI_BITS];
                `PTC_OFS_LO_LO: lo_q[7:0] <= wdata_q;
                `PTC_OFS_LO_HI: lo_q[10:8] <= wdata_q[`PTC_HI_BITS];
                `PTC_OFS_COMP_HI: comp_q[10:8] <= wdata_q[`PTC_HI_BITS];
                `PTC_OFS_COMP_LO: comp_q[7:0] <= wdata_q;
                `PTC_OFS_FILT: filt_q <= wdata_q[`PTC_FILT_CNT];
                default: ; // Read-only and unmapped ignored
            endcase
        end
    end

    // Compensation and window compare
    logic active;
    logic [RES_W-1:0] comp_val;
    logic sat_val;
    logic outlier;
    assign active = (ctrl_q[`PTC_CTRL_ACTIVE] == 2'b11);
    // Floor at zero when the offset exceeds the raw value
    assign comp_val = (raw_data > comp_q) ? (raw_data - comp_q) : '0;
    assign sat_val = raw_sat & ctrl_q[`PTC_CTRL_SAT_EN];
    assign outlier = (comp_val > up_q) || (comp_val < lo_q);

    // Result holding with read lock
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            res_q <= '0;
            res_sat_q <= 1'b0;
            pend_q <= '0;
            pend_sat_q <= 1'b0;
            pend_vld_q <= 1'b0;
        end else if (raw_valid && active) begin
            if (lock) begin
                pend_q <= comp_val;
                pend_sat_q <= sat_val;
                pend_vld_q <= 1'b1;
            end else begin
                res_q <= comp_val;
                res_sat_q <= sat_val;
                pend_vld_q <= 1'b0;
            end
        end else if (pend_vld_q && !lock) begin
            res_q <= pend_q;
            res_sat_q <= pend_sat_q;
            pend_vld_q <= 1'b0;
        end
    end

    // New data flag, set wins over read clear
    logic res_load;
    assign res_load = (raw_valid && active && !lock) || (pend_vld_q && !lock);
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            new_q <= 1'b0;
        end else if (res_load) begin
            new_q <= 1'b1;
        end else if (rd_q && rptr_q == `PTC_OFS_RES_HI) begin
            new_q <= 1'b0;
        end
    end

    // Out-of-range run counter and interrupt flag
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            run_q <= 4'h0;
            irq_flag_q <= 1'b0;
        end else begin
            if (raw_valid && active) begin
                if (!outlier) begin
                    run_q <= 4'h0;
                end else if (run_q >= filt_q) begin
                    irq_flag_q <= 1'b1;
                end else begin
                    run_q <= run_q + 4'h1;
                end
            end
            // Reading the flags clears the interrupt unless it is set now
            if (rd_q && rptr_q == `PTC_OFS_FLAGS &&
                !(raw_valid && active && outlier && run_q >= filt_q)) begin
                irq_flag_q <= 1'b0;
            end
        end
    end

    // Output pins and settings
    always_ff @(posedge clock or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
            int_o <= 1'b0;
            int_oe <= 1'b0;
            meas_cfg <= '0;
            emitter <= '0;
            result <= '0;
        end else begin
            sda_o <= 1'b0;
            sda_oe <= oe_q;
            int_oe <= (irq_q[`PTC_IRQ_MODE] != 2'b00);
            int_o <= irq_q[`PTC_IRQ_POL] ? irq_flag_q : ~irq_flag_q;
            meas_cfg.enable <= active;
            meas_cfg.gain <= ctrl_q[`PTC_CTRL_GAIN];
            meas_cfg.rate <= rate_q[3:0];
            emitter.freq <= emit_q[`PTC_EMIT_FREQ];
            emitter.duty <= emit_q[`PTC_EMIT_DUTY];
            emitter.current <= emit_q[`PTC_EMIT_CURR];
            result <= res_q;
        end
    end

endmodule : ptc_regs
`default_nettype wire

// >>> tb/ptc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.svh"

module ptc_host_model (
    input wire logic clock, // System clock
    input wire logic sda, // Resolved data wire
    output logic scl, // Serial clock
    output logic sda_pull // High pulls data low
);
    localparam int PH = 4; // Clocks per clock phase

    // Bus idle at power up
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // One phase of the serial clock
    task automatic ph();
        repeat (PH) @(negedge clock);
    endtask : ph

    // One bit out, wire level seen with clock high
    task automatic bit_io(input logic b, output logic seen);
        sda_pull = !b;
        ph();
        scl = 1'b1;
        ph();
        seen = sda;
        scl = 1'b0;
        @(negedge clock);
    endtask : bit_io

    // Start or repeated start
    task automatic start();
        sda_pull = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_pull = 1'b1;
        ph();
        scl = 1'b0;
        @(negedge clock);
    endtask : start

    // Stop, bus released
    task automatic stop();
        sda_pull = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_pull = 1'b0;
        ph();
    endtask : stop

    // Byte out, acknowledge level back
    task automatic put(input logic [7:0] v, output logic nak);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(v[i], s);
        end
        bit_io(1'b1, nak);
    endtask : put

    // Single-byte register write
    task automatic wr(input logic [6:0] a, input logic [7:0] r, d, output logic nak);
        logic k;
        start();
        put({a, 1'b0}, nak);
        if (!nak) begin // Rest only when addressed
            put(r, k);
            put(d, k);
        end
        stop();
    endtask : wr

    // Register read of n bytes after a repeated start
    task automatic rd(input logic [7:0] r, input int n, output logic [15:0] d);
        logic k;
        start();
        put({`PTC_DEV_ADDR, 1'b0}, k);
        put(r, k);
        start();
        put({`PTC_DEV_ADDR, 1'b1}, k);
        d = 16'h0000;
        for (int j = 0; j < n; j++) begin
            for (int i = 0; i < 8; i++) begin
                bit_io(1'b1, k);
                d = {d[14:0], k};
            end
            bit_io(j == n - 1, k); // Acknowledge all but last
        end
        stop();
    endtask : rd
endmodule : ptc_host_model

`default_nettype wire

// >>> tb/ptc_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none

module ptc_regs_sva
    import ptc_pkg::*;
#(
    parameter int RES_W = 11 // Result width
) (
    input wire logic clock, // System clock
    input wire logic rst_n, // Reset, active low
    input wire logic scl_i, // Serial clock
    input wire logic sda_i, // Data wire
    input wire logic sda_o, // Data drive level
    input wire logic sda_oe, // Data drive enable
    input wire logic int_oe, // Interrupt enable
    input wire ptc_meas_cfg_t meas_cfg, // Measurement settings
    input wire ptc_emitter_t emitter, // Emitter settings
    input wire logic [RES_W-1:0] result // Compensated result
);
    logic scl_p; // Last clock level
    logic sda_p; // Last data level
    logic busy_q; // Between start and stop

    // Follow start and stop on the wire
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            scl_p <= scl_i;
            sda_p <= sda_i;
            if (scl_i && scl_p && sda_p && !sda_i) begin // Start
                busy_q <= 1'b1;
            end else if (scl_i && scl_p && !sda_p && sda_i) begin // Stop
                busy_q <= 1'b0;
            end
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_released; $rose(rst_n); endsequence // First edge out of reset
    sequence s_busy_long; busy_q [*8]; endsequence // Deep in a transaction
    sequence s_idle_long; (!busy_q) [*6]; endsequence // Bus quiet

    a_sda_open_drain: assert property (sda_oe |-> !sda_o)
        else $error("data line driven high");
    a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
        else $error("data drive moved with clock high");
    a_idle_no_drive: assert property (!busy_q && !$past(busy_q) |-> !sda_oe)
        else $error("data driven outside a transaction");
    a_result_frozen: assert property (s_busy_long |-> $stable(result))
        else $error("result moved during a transaction");
    a_emit_idle: assert property (s_idle_long |-> $stable(emitter))
        else $error("emitter moved with bus idle");
    a_emit_reset: assert property (s_released |-> ##[2:4] (emitter == 8'h7F))
        else $error("emitter not at reset value");
    a_cfg_reset: assert property (s_released |-> ##[2:4] (meas_cfg == 7'h02))
        else $error("settings not at reset value");
    a_int_float_rst: assert property (s_released |-> (!int_oe) [*4])
        else $error("interrupt pin driven after reset");
endmodule : ptc_regs_sva

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ptc_consts.svh"

// Compare, count and report
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin bad_count++; \
    $display("BAD %s expected %0h seen %0h", nm, e, s); end end

module testbench;
    import ptc_pkg::*;

    localparam logic [10:0] COMP = 11'h105; // Compensation in use

    logic clock = 1'b0; // System clock
    logic rst_n; // Reset, active low
    logic scl; // Serial clock
    logic pull; // Host pulls data
    logic raw_valid; // Raw strobe
    logic raw_sat = 1'b0; // Saturation, held low
    logic [10:0] raw_data; // Raw result
    logic [10:0] result; // Compensated result
    logic sda_o; // Device data level
    logic sda_oe; // Device data enable
    logic int_o; // Interrupt level
    logic int_oe; // Interrupt enable
    logic nak; // No acknowledge
    logic [15:0] rdv; // Read data
    ptc_meas_cfg_t meas_cfg; // Measurement settings
    ptc_emitter_t emitter; // Emitter settings
    int bad_count = 0; // Mismatches
    int checks = 0; // Comparisons
    wire logic sda = !pull && (!sda_oe || sda_o); // Open drain, pulled up
    wire logic int_pin = int_oe ? int_o : 1'b1; // Pulled up when floating

    // 25 MHz clock
    always #20 clock = ~clock;

    ptc_regs dut (.clock(clock), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe), .int_o(int_o), .int_oe(int_oe), .raw_valid(raw_valid),
        .raw_data(raw_data), .raw_sat(raw_sat), .meas_cfg(meas_cfg), .emitter(emitter),
        .result(result));
    ptc_host_model host (.clock(clock), .sda(sda), .scl(scl), .sda_pull(pull));

    // Acknowledged write
    task automatic wreg(input logic [7:0] r, input logic [7:0] d);
        host.wr(`PTC_DEV_ADDR, r, d, nak);
        `CHK("ack", 1'b0, nak)
    endtask : wreg

    // Read and compare one register
    task automatic rchk(input logic [7:0] r, input logic [7:0] e);
        host.rd(r, 1, rdv);
        `CHK($sformatf("reg %h", r), e, rdv[7:0])
    endtask : rchk

    // One raw result, then the settled result
    task automatic meas(input logic [10:0] raw, input logic [10:0] e);
        raw_data = raw;
        raw_valid = 1'b1;
        @(negedge clock);
        raw_valid = 1'b0;
        repeat (4) @(negedge clock);
        `CHK("result", e, result)
    endtask : meas

    // Reset values, unmapped read, standby ignores results
    task automatic t_reset();
        logic [15:0] t [12] = '{16'h8100, 16'h827F, 16'h8402, 16'h8C00, 16'h90FF,
            16'h9107, 16'h9200, 16'h9300, 16'h9400, 16'h9500, 16'h9E00, 16'h8000};
        foreach (t[i]) begin
            rchk(t[i][15:8], t[i][7:0]);
        end
        `CHK("emitter", 8'h7F, emitter)
        `CHK("cfg", 7'h02, meas_cfg)
        meas(11'h123, 11'h000);
    endtask : t_reset

    // Fourteen emitter codes reach the driver port, each duty setting among them
    task automatic t_emitter();
        logic [7:0] c [14] = '{8'h1F, 8'h3F, 8'h5F, 8'h7F, 8'h9F, 8'hBF, 8'hFF,
            8'h67, 8'h6F, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h7B};
        foreach (c[i]) begin
            wreg(8'h82, c[i]);
            `CHK("emitter", c[i], emitter)
        end
    endtask : t_emitter

    // Enable with gains 0, 2 and 3
    task automatic t_control();
        logic [7:0] c [3] = '{8'h03, 8'h0B, 8'h0F};
        foreach (c[i]) begin
            wreg(8'h81, c[i]);
            `CHK("gain", {1'b1, c[i][3:2]}, meas_cfg[6:4])
        end
    endtask : t_control

    // Offset subtraction, byte pairing, new-data flag, clamp
    task automatic t_comp();
        wreg(8'h94, 8'h01);
        wreg(8'h95, 8'h05);
        meas(11'h300, 11'h1FB);
        rchk(8'h8C, 8'h01);
        host.rd(8'h8D, 2, rdv);
        `CHK("pair", 16'hFB01, rdv)
        rchk(8'h8C, 8'h00);
        meas(11'h100, 11'h000);
    endtask : t_comp

    // Reserved bits, read-only status, fast rate
    task automatic t_reserved();
        logic [23:0] t [5] = '{24'h91FF07, 24'h93FF07, 24'h94FF07, 24'h9EFFF0, 24'h8CFF01};
        foreach (t[i]) begin
            wreg(t[i][23:16], t[i][15:8]);
            rchk(t[i][23:16], t[i][7:0]);
        end
        wreg(8'h84, 8'h00);
        `CHK("rate", 4'h0, meas_cfg.rate)
    endtask : t_reserved

    // Window, persistence, polarity and floating pin
    task automatic t_persist();
        logic [11:0] s [6] = '{12'h500, 12'h010, 12'h200, 12'h500, 12'h500, 12'h810};
        logic [15:0] w [7] = '{16'h9401, 16'h90E8, 16'h9103, 16'h9264, 16'h9300,
            16'h8F05, 16'h9E20};
        foreach (w[i]) begin
            wreg(w[i][15:8], w[i][7:0]);
        end
        foreach (s[i]) begin
            meas(s[i][10:0] + COMP, s[i][10:0]);
            `CHK("int", s[i][11], int_pin)
        end
        rchk(8'h8C, 8'h03);
        `CHK("int", 1'b0, int_pin)
        wreg(8'h8F, 8'h01);
        wreg(8'h9E, 8'h00);
        meas(11'h200 + COMP, 11'h200);
        `CHK("int", 1'b1, int_pin)
        meas(11'h500 + COMP, 11'h500);
        `CHK("int", 1'b0, int_pin)
        wreg(8'h8F, 8'h00);
        `CHK("int", 1'b1, int_pin)
        rchk(8'h8C, 8'h03);
    endtask : t_persist

    // Longest run before the interrupt
    task automatic t_persist_max();
        wreg(8'h8F, 8'h05);
        wreg(8'h9E, 8'hF0);
        meas(11'h200 + COMP, 11'h200);
        for (int i = 0; i < 16; i++) begin
            meas(11'h500 + COMP, 11'h500);
            `CHK("int", i == 15, int_pin)
        end
    endtask : t_persist_max

    // New result during a two-byte read waits for the stop
    task automatic t_freeze();
        fork
            host.rd(8'h8D, 2, rdv);
            begin
                repeat (300) @(negedge clock);
                raw_data = 11'h234 + COMP;
                raw_valid = 1'b1;
                @(negedge clock);
                raw_valid = 1'b0;
            end
        join
        `CHK("frozen", 16'h0005, rdv)
        repeat (4) @(negedge clock);
        `CHK("result", 11'h234, result)
    endtask : t_freeze

    // Another slave address is ignored
    task automatic t_wrong_addr();
        host.wr(7'h24, 8'h84, 8'h05, nak);
        `CHK("nak", 1'b1, nak)
        rchk(8'h84, 8'h00);
    endtask : t_wrong_addr

    // Counts and verdict
    task automatic print_verdict();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // Hang guard
    initial begin
        repeat (60000) @(posedge clock);
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        raw_valid = 1'b0;
        raw_data = 11'h000;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        t_reset();
        t_emitter();
        t_control();
        t_comp();
        t_reserved();
        t_persist();
        t_persist_max();
        t_freeze();
        t_wrong_addr();
        print_verdict();
    end
endmodule : testbench

bind ptc_regs ptc_regs_sva #(.RES_W(RES_W)) chk (.*);

`default_nettype wire
